/* File: ssft_timer.sv */
// shared constants and the tick-driven delay timer of the supply sequencer
`timescale 1ns/10ps
`default_nettype none
package ssft_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 500000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int GLITCH_NS = 3000;
    localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NOISE_NS = 100;
    localparam int NOISE_CYCLES = (NOISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TW = 10;
    // delays in 0.5 ms ticks
    localparam logic [TW-1:0] T_1P5MS = 10'h003;
    localparam logic [TW-1:0] T_3MS = 10'h006;
    localparam logic [TW-1:0] T_12P5MS = 10'h019;
    localparam logic [TW-1:0] T_25MS = 10'h032;
    localparam logic [TW-1:0] T_50MS = 10'h064;
    localparam logic [TW-1:0] T_100MS = 10'h0c8;
    localparam logic [TW-1:0] T_200MS = 10'h190;
    localparam logic [TW-1:0] T_400MS = 10'h320;
    localparam logic [TW-1:0] T_ZERO = 10'h000;
    localparam logic [11:0] LEVEL_BASE_MV = 12'h9f6;
    localparam logic [11:0] LEVEL_STEP_MV = 12'h096;
    localparam logic [4:0] PCT_STEP = 5'h05;
    localparam logic [1:0] ABORT_OFF = 2'h0;
endpackage : ssft_pkg

module ssft_timer (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic active,
    input wire logic tick,
    input wire logic [ssft_pkg::TW-1:0] limit,
    output logic done
);
    logic [ssft_pkg::TW-1:0] cnt_r;

    // cleared whenever inactive, so each entry restarts the count
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cnt_r <= ssft_pkg::T_ZERO;
        else if (!active)
            cnt_r <= ssft_pkg::T_ZERO;
        else if (tick && cnt_r < limit)
            cnt_r <= cnt_r + 1'b1;
    end

    assign done = active && (cnt_r >= limit);
endmodule : ssft_timer
`default_nettype wire

/* File: ssft_sequencer.sv */
// power sequencer, supervisors, fault filters and comparator threshold selection
// Notes on behaviour
// - wait selected 1.5/12.5/25/50 ms between sequence positions, up and down
// - hold system reset low 25/50/100/200 ms after last supply good
// - channel must reach good within 50/100/200 ms or off, else shutdown
// - debounce power request pin 0/25/100/400 ms before acting
// - supply fail indication stays active 3 ms after latch cleared
// - battery fault output stays low 3 ms after fault disappears
// - supply faults act only after persisting 3 us continuously
// - battery fault level 2.55 V to 3.60 V, 150 mV steps from lowest
// - supply fail level same range, own independent step code
// - per channel undervolt and overvolt limits 5/10/15/20 percent
// - serial bus lines ignore noise pulses of 100 ns or less
// - forced shutdown disables every channel at once
`timescale 1ns/10ps
`default_nettype none
module ssft_sequencer #(
    parameter int N = 6,
    parameter int TICK_CYCLES = ssft_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic power_request_pin,
    input wire logic [1:0] request_debounce_sel,
    input wire logic [2*N-1:0] seq_on_delay_sel,
    input wire logic [2*N-1:0] seq_off_delay_sel,
    input wire logic [1:0] reset_release_sel,
    input wire logic [1:0] seq_abort_sel,
    input wire logic force_shutdown_req,
    input wire logic [N-1:0] ch_power_good,
    input wire logic [N-1:0] ch_fault,
    output logic [N-1:0] ch_enable,
    output logic system_reset_out_n,
    input wire logic battery_low,
    output logic battery_fault_out_n,
    input wire logic supply_fail_cmp,
    input wire logic supply_fail_clear,
    output logic supply_fail_out,
    input wire logic [2:0] battery_fault_level_code,
    input wire logic [2:0] supply_fail_level_code,
    output logic [11:0] battery_fault_level,
    output logic [11:0] supply_fail_level,
    input wire logic [2*N-1:0] undervolt_sel,
    input wire logic [2*N-1:0] overvolt_sel,
    output logic [5*N-1:0] undervolt_limit_pct,
    output logic [5*N-1:0] overvolt_limit_pct,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_filt,
    output logic sda_filt
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ON_WAIT = 7'h02,
        ST_ON_DELAY = 7'h04,
        ST_RST_DELAY = 7'h08,
        ST_RUN = 7'h10,
        ST_OFF_WAIT = 7'h20,
        ST_OFF_DELAY = 7'h40
    } ssft_state_e;

    localparam int PW = $clog2(N);
    localparam logic [PW-1:0] LAST_POS = PW'(N-1);
    localparam int TCW = $clog2(TICK_CYCLES);
    localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES-1);
    localparam int GW = $clog2(ssft_pkg::GLITCH_CYCLES+1);
    localparam logic [GW-1:0] GLITCH_LAST = GW'(ssft_pkg::GLITCH_CYCLES);

    function automatic logic [ssft_pkg::TW-1:0] step_ticks(input logic [1:0] s);
        case (s)
            2'h0: step_ticks = ssft_pkg::T_1P5MS;
            2'h1: step_ticks = ssft_pkg::T_12P5MS;
            2'h2: step_ticks = ssft_pkg::T_25MS;
            default: step_ticks = ssft_pkg::T_50MS;
        endcase
    endfunction : step_ticks

    function automatic logic [11:0] level_mv(input logic [2:0] code);
        level_mv = ssft_pkg::LEVEL_BASE_MV + 12'(code * ssft_pkg::LEVEL_STEP_MV);
    endfunction : level_mv

    function automatic logic [4:0] pct(input logic [1:0] s);
        pct = 5'(({3'h0, s} + 5'h01) * ssft_pkg::PCT_STEP);
    endfunction : pct

    // synchronisers: first stage read only by second
    localparam int NS = 2*N + 5;
    logic [NS-1:0] sync1_r, sync2_r;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {sda_in, scl_in, supply_fail_cmp, battery_low, power_request_pin, ch_fault, ch_power_good};
            sync2_r <= sync1_r;
        end
    end
    logic [N-1:0] good_s, fault_s;
    logic req_s, batt_s, sfcmp_s, scl_s, sda_s;
    assign good_s = sync2_r[N-1:0];
    assign fault_s = sync2_r[2*N-1:N];
    assign {sda_s, scl_s, sfcmp_s, batt_s, req_s} = sync2_r[NS-1:2*N];

    // bus line noise filter
    logic scl_d_r, sda_d_r;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            scl_filt <= 1'b1;
            sda_filt <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            if (scl_d_r == scl_s)
                scl_filt <= scl_s;
            if (sda_d_r == sda_s)
                sda_filt <= sda_s;
        end
    end

    // common time base
    logic [TCW-1:0] tb_r;
    logic tick;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            tb_r <= '0;
        else if (tb_r == TICK_LAST)
            tb_r <= '0;
        else
            tb_r <= tb_r + 1'b1;
    end
    assign tick = (tb_r == TICK_LAST);

    // supply fault glitch filters
    logic [GW-1:0] gcnt_r [N];
    logic [N-1:0] fault_ok;
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_filt
            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                    gcnt_r[gi] <= '0;
                else if (!fault_s[gi])
                    gcnt_r[gi] <= '0;
                else if (gcnt_r[gi] != GLITCH_LAST)
                    gcnt_r[gi] <= gcnt_r[gi] + 1'b1;
            end
            assign fault_ok[gi] = (gcnt_r[gi] == GLITCH_LAST);
            assign undervolt_limit_pct[5*gi +: 5] = pct(undervolt_sel[2*gi +: 2]);
            assign overvolt_limit_pct[5*gi +: 5] = pct(overvolt_sel[2*gi +: 2]);
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            battery_fault_level <= ssft_pkg::LEVEL_BASE_MV;
            supply_fail_level <= ssft_pkg::LEVEL_BASE_MV;
        end
        else
        begin
            battery_fault_level <= level_mv(battery_fault_level_code);
            supply_fail_level <= level_mv(supply_fail_level_code);
        end
    end

    // power request debounce
    logic req_db_r, db_done;
    logic [ssft_pkg::TW-1:0] db_lim;
    always_comb
    begin
        case (request_debounce_sel)
            2'h0: db_lim = ssft_pkg::T_ZERO;
            2'h1: db_lim = ssft_pkg::T_25MS;
            2'h2: db_lim = ssft_pkg::T_100MS;
            default: db_lim = ssft_pkg::T_400MS;
        endcase
    end
    ssft_timer u_db (.clk_sys(clk_sys), .rstn(rstn), .active(req_s != req_db_r), .tick(tick),
        .limit(db_lim), .done(db_done));
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            req_db_r <= 1'b0;
        else if (db_done)
            req_db_r <= req_s;
    end

    // battery fault hold
    logic bf_hold_r, bf_done;
    ssft_timer u_bf (.clk_sys(clk_sys), .rstn(rstn), .active(bf_hold_r && !batt_s), .tick(tick),
        .limit(ssft_pkg::T_3MS), .done(bf_done));
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            bf_hold_r <= 1'b0;
        else if (batt_s)
            bf_hold_r <= 1'b1;
        else if (bf_done)
            bf_hold_r <= 1'b0;
    end
    assign battery_fault_out_n = !(batt_s || bf_hold_r);

    // supply fail latch and hold
    logic sf_latch_r, sf_hold_r, sf_done;
    ssft_timer u_sf (.clk_sys(clk_sys), .rstn(rstn), .active(sf_hold_r && !sf_latch_r), .tick(tick),
        .limit(ssft_pkg::T_3MS), .done(sf_done));
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sf_latch_r <= 1'b0;
            sf_hold_r <= 1'b0;
        end
        else
        begin
            if (sfcmp_s)
                sf_latch_r <= 1'b1;
            else if (supply_fail_clear)
                sf_latch_r <= 1'b0;
            if (sf_latch_r || sfcmp_s)
                sf_hold_r <= 1'b1;
            else if (sf_done)
                sf_hold_r <= 1'b0;
        end
    end
    assign supply_fail_out = sf_latch_r || sf_hold_r;

    // sequencer
    ssft_state_e state_r;
    logic [PW-1:0] pos_r;
    logic dly_done, abort_done, shutdown;
    logic [ssft_pkg::TW-1:0] dly_lim, abort_lim;
    always_comb
    begin
        case (state_r)
            ST_ON_DELAY: dly_lim = step_ticks(seq_on_delay_sel[2*pos_r +: 2]);
            ST_OFF_DELAY: dly_lim = step_ticks(seq_off_delay_sel[2*pos_r +: 2]);
            default: dly_lim = (reset_release_sel == 2'h0) ? ssft_pkg::T_25MS :
                (reset_release_sel == 2'h1) ? ssft_pkg::T_50MS :
                (reset_release_sel == 2'h2) ? ssft_pkg::T_100MS : ssft_pkg::T_200MS;
        endcase
        case (seq_abort_sel)
            2'h1: abort_lim = ssft_pkg::T_50MS;
            2'h2: abort_lim = ssft_pkg::T_100MS;
            default: abort_lim = ssft_pkg::T_200MS;
        endcase
    end
    ssft_timer u_dly (.clk_sys(clk_sys), .rstn(rstn),
        .active(state_r == ST_ON_DELAY || state_r == ST_OFF_DELAY || state_r == ST_RST_DELAY),
        .tick(tick), .limit(dly_lim), .done(dly_done));
    ssft_timer u_abort (.clk_sys(clk_sys), .rstn(rstn),
        .active((state_r == ST_ON_WAIT || state_r == ST_OFF_WAIT) && seq_abort_sel != ssft_pkg::ABORT_OFF),
        .tick(tick), .limit(abort_lim), .done(abort_done));

    assign shutdown = force_shutdown_req || batt_s || (|fault_ok) || abort_done;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            pos_r <= '0;
            ch_enable <= '0;
            system_reset_out_n <= 1'b0;
        end
        else if (shutdown && state_r != ST_IDLE)
        begin
            state_r <= ST_IDLE;
            ch_enable <= '0;
            system_reset_out_n <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (req_db_r && !shutdown)
                    begin
                        pos_r <= '0;
                        ch_enable[0] <= 1'b1;
                        state_r <= ST_ON_WAIT;
                    end
                ST_ON_WAIT:
                    if (good_s[pos_r])
                        state_r <= (pos_r == LAST_POS) ? ST_RST_DELAY : ST_ON_DELAY;
                ST_ON_DELAY:
                    if (dly_done)
                    begin
                        pos_r <= pos_r + 1'b1;
                        ch_enable[pos_r + 1'b1] <= 1'b1;
                        state_r <= ST_ON_WAIT;
                    end
                ST_RST_DELAY:
                    if (dly_done)
                    begin
                        system_reset_out_n <= 1'b1;
                        state_r <= ST_RUN;
                    end
                ST_RUN:
                    if (!req_db_r)
                    begin
                        pos_r <= LAST_POS;
                        ch_enable[LAST_POS] <= 1'b0;
                        system_reset_out_n <= 1'b0;
                        state_r <= ST_OFF_WAIT;
                    end
                ST_OFF_WAIT:
                    if (!good_s[pos_r])
                        state_r <= (pos_r == '0) ? ST_IDLE : ST_OFF_DELAY;
                ST_OFF_DELAY:
                    if (dly_done)
                    begin
                        pos_r <= pos_r - 1'b1;
                        ch_enable[pos_r - 1'b1] <= 1'b0;
                        state_r <= ST_OFF_WAIT;
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule : ssft_sequencer
`default_nettype wire

/* File: ssft_sequencer_checker.sv */
// concurrent checks on the supply sequencer ports
`timescale 1ns/10ps
`default_nettype none
module ssft_sequencer_checker #(
    parameter int N = 6,
    parameter int TICK_CYCLES = ssft_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic force_shutdown_req,
    input wire logic [N-1:0] ch_enable,
    input wire logic system_reset_out_n,
    input wire logic battery_low,
    input wire logic battery_fault_out_n,
    input wire logic supply_fail_cmp,
    input wire logic supply_fail_out,
    input wire logic [2:0] battery_fault_level_code,
    input wire logic [11:0] battery_fault_level,
    input wire logic [2*N-1:0] undervolt_sel,
    input wire logic [5*N-1:0] undervolt_limit_pct,
    input wire logic scl_in,
    input wire logic scl_filt
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    localparam int HOLD_LO = 5 * TICK_CYCLES - 2;
    localparam int HOLD_HI = 7 * TICK_CYCLES + 4;
    logic [15:0] hold_cnt_r;
    // cycles the fault output stays low after the comparator cleared
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            hold_cnt_r <= 16'h0000;
        else if (battery_low)
            hold_cnt_r <= 16'h0000;
        else if (!battery_fault_out_n)
            hold_cnt_r <= hold_cnt_r + 16'h0001;
    end
    function automatic logic pct_ok(input logic [2*N-1:0] s, input logic [5*N-1:0] p);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < N; i++)
            ok &= (p[5*i+:5] == 5'h05 * ({3'h0, s[2*i+:2]} + 5'h01));
        return ok;
    endfunction : pct_ok
    sequence s_low_rise;
        $rose(battery_low);
    endsequence
    sequence s_fault_shown;
        ##[1:3] !battery_fault_out_n;
    endsequence
    a_all_off_forced: assert property (force_shutdown_req && |ch_enable |=> ch_enable == '0 && !system_reset_out_n)
        else $error("enables not cleared by forced shutdown");
    a_reset_needs_all: assert property (system_reset_out_n |-> &ch_enable)
        else $error("system reset released with a channel off");
    a_on_step_next: assert property ((ch_enable & ~$past(ch_enable)) != '0 |-> ch_enable == {$past(ch_enable[N-2:0]), 1'b1})
        else $error("enable rose out of order");
    a_off_step_prev: assert property ((~ch_enable & $past(ch_enable)) != '0 |-> ch_enable == '0 || ch_enable == ($past(ch_enable) >> 1))
        else $error("enable fell out of order");
    a_batt_level_code: assert property (battery_fault_level == 12'h9f6 + 12'h096 * {9'h000, $past(battery_fault_level_code)})
        else $error("battery level does not follow code");
    a_uv_pct_code: assert property (pct_ok(undervolt_sel, undervolt_limit_pct))
        else $error("undervolt percent does not follow select");
    a_batt_low_seen: assert property (s_low_rise |-> s_fault_shown)
        else $error("battery fault output not asserted");
    a_batt_hold_time: assert property ($rose(battery_fault_out_n) |-> hold_cnt_r >= HOLD_LO && hold_cnt_r <= HOLD_HI)
        else $error("battery fault hold time wrong");
    a_fail_latch_set: assert property ($rose(supply_fail_cmp) |-> ##[1:4] supply_fail_out)
        else $error("supply fail indication not set");
    a_scl_follows: assert property ($stable(scl_in) [*6] |-> scl_filt == scl_in)
        else $error("filtered clock line does not follow a steady input");
endmodule : ssft_sequencer_checker
bind ssft_sequencer ssft_sequencer_checker #(.N(N), .TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys(clk_sys),
    .rstn(rstn), .force_shutdown_req(force_shutdown_req), .ch_enable(ch_enable),
    .system_reset_out_n(system_reset_out_n), .battery_low(battery_low), .battery_fault_out_n(battery_fault_out_n),
    .supply_fail_cmp(supply_fail_cmp), .supply_fail_out(supply_fail_out),
    .battery_fault_level_code(battery_fault_level_code), .battery_fault_level(battery_fault_level),
    .undervolt_sel(undervolt_sel), .undervolt_limit_pct(undervolt_limit_pct), .scl_in(scl_in), .scl_filt(scl_filt));
`default_nettype wire

/* File: ssft_rail_model.sv */
// regulator channels answering the sequencer enables
`timescale 1ns/10ps
`default_nettype none
module ssft_rail_model #(
    parameter int N = 6
) (
    input wire logic clk_sys,
    input wire logic [N-1:0] ch_enable,
    input wire logic slow,
    input wire logic stuck,
    output logic [N-1:0] ch_power_good
);
    logic [N-1:0] en_d1 = '0;
    logic [N-1:0] en_d2 = '0;
    int up[N];
    // good after a ramp, lost a few cycles after disable; stuck holds the last rail low
    always_ff @(posedge clk_sys)
    begin
        en_d1 <= ch_enable;
        en_d2 <= en_d1;
        for (int i = 0; i < N; i++)
        begin
            up[i] <= ch_enable[i] ? up[i] + 1 : 0;
            ch_power_good[i] <= en_d2[i] && up[i] >= (slow ? 40 : 4) && !(stuck && i == N - 1);
        end
    end
endmodule : ssft_rail_model
`default_nettype wire

/* File: test_ssft_sequencer.sv */
// self-checking bench for the supply sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %0h exp %0h", $time, got, exp); end end
module test_ssft_sequencer;
    localparam int N = 3;
    localparam int T = 10;
    logic clk_sys = 1'b0, rstn = 1'b0, power_request_pin = 1'b0, force_shutdown_req = 1'b0, battery_low = 1'b0;
    logic supply_fail_cmp = 1'b0, supply_fail_clear = 1'b0, scl_in = 1'b1, sda_in = 1'b1, slow = 1'b0, stuck = 1'b0;
    logic [1:0] request_debounce_sel = 2'h0, reset_release_sel = 2'h0, seq_abort_sel = 2'h0;
    logic [2*N-1:0] seq_on_delay_sel = 6'h0c, seq_off_delay_sel = 6'h18, undervolt_sel = 6'h00, overvolt_sel = 6'h00;
    logic [2:0] battery_fault_level_code = 3'h0, supply_fail_level_code = 3'h0;
    logic [N-1:0] ch_fault = '0, ch_enable, ch_power_good;
    logic system_reset_out_n, battery_fault_out_n, supply_fail_out, scl_filt, sda_filt;
    logic [11:0] battery_fault_level, supply_fail_level;
    logic [5*N-1:0] undervolt_limit_pct, overvolt_limit_pct;
    int fail_count = 0, comparisons = 0, cycles = 0;
    int db_t[4] = '{0, 500, 2000, 8000};
    int rr_t[4] = '{500, 1000, 2000, 4000};
    ssft_sequencer #(.N(N), .TICK_CYCLES(T)) uut (.clk_sys(clk_sys), .rstn(rstn),
        .power_request_pin(power_request_pin), .request_debounce_sel(request_debounce_sel),
        .seq_on_delay_sel(seq_on_delay_sel), .seq_off_delay_sel(seq_off_delay_sel),
        .reset_release_sel(reset_release_sel), .seq_abort_sel(seq_abort_sel), .force_shutdown_req(force_shutdown_req),
        .ch_power_good(ch_power_good), .ch_fault(ch_fault), .ch_enable(ch_enable),
        .system_reset_out_n(system_reset_out_n), .battery_low(battery_low), .battery_fault_out_n(battery_fault_out_n),
        .supply_fail_cmp(supply_fail_cmp), .supply_fail_clear(supply_fail_clear), .supply_fail_out(supply_fail_out),
        .battery_fault_level_code(battery_fault_level_code), .supply_fail_level_code(supply_fail_level_code),
        .battery_fault_level(battery_fault_level), .supply_fail_level(supply_fail_level),
        .undervolt_sel(undervolt_sel), .overvolt_sel(overvolt_sel), .undervolt_limit_pct(undervolt_limit_pct),
        .overvolt_limit_pct(overvolt_limit_pct), .scl_in(scl_in), .sda_in(sda_in), .scl_filt(scl_filt),
        .sda_filt(sda_filt));
    ssft_rail_model #(.N(N)) rails (.clk_sys(clk_sys), .ch_enable(ch_enable), .slow(slow), .stuck(stuck),
        .ch_power_good(ch_power_good));
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            fail_count++;
            finish_test();
        end
    end
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    function automatic logic cur(input int s);
        return s < N ? ch_enable[s] : s == N ? system_reset_out_n : s == N + 1 ? battery_fault_out_n : supply_fail_out;
    endfunction : cur
    // count cycles until the watched output reaches v, then judge against exp within one tick below and one tick plus 8 cycles above
    task automatic wait_for(input int s, input logic v, input int exp);
        int k;
        k = 0;
        while (cur(s) !== v && k < 20000)
        begin
            step(1);
            k++;
        end
        `CHK(k >= exp - T && k <= exp + T + 8, 1'b1)
    endtask : wait_for
    task automatic power_up(input int i, input bit full);
        int r;
        r = (i == 2) ? 46 : 10;
        request_debounce_sel = 2'(i);
        reset_release_sel = 2'(i);
        slow = (i == 2);
        step(20 * T);
        if (i > 0)
        begin
            power_request_pin = 1'b1;
            step(db_t[i] / 2);
            power_request_pin = 1'b0;
            step(db_t[i]);
            `CHK(ch_enable, 3'h0)
        end
        power_request_pin = 1'b1;
        wait_for(0, 1'b1, db_t[i] + 4);
        wait_for(1, 1'b1, 30 + r);
        wait_for(2, 1'b1, 1000 + r);
        if (full)
            wait_for(N, 1'b1, rr_t[i] + r);
    endtask : power_up
    task automatic power_down(input int i);
        power_request_pin = 1'b0;
        wait_for(2, 1'b0, db_t[i] + 4);
        `CHK(system_reset_out_n, 1'b0)
        wait_for(1, 1'b0, 256);
        wait_for(0, 1'b0, 506);
    endtask : power_down
    task automatic force_idle;
        force_shutdown_req = 1'b1;
        step(3);
        power_request_pin = 1'b0;
        step(3);
        force_shutdown_req = 1'b0;
    endtask : force_idle
    initial
    begin
        step(16);
        `CHK({ch_enable, system_reset_out_n, battery_fault_out_n, supply_fail_out, scl_filt, sda_filt}, 8'h0b)
        rstn = 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            battery_fault_level_code = 3'(c);
            supply_fail_level_code = 3'(7 - c);
            undervolt_sel = {N{2'(c)}};
            overvolt_sel = {N{2'(c + 1)}};
            step(2);
            `CHK(battery_fault_level, 12'h9f6 + 12'h096 * 12'(c))
            `CHK(supply_fail_level, 12'h9f6 + 12'h096 * 12'(7 - c))
            `CHK(undervolt_limit_pct, {N{5'(5 * (c % 4 + 1))}})
            `CHK(overvolt_limit_pct, {N{5'(5 * ((c + 1) % 4 + 1))}})
        end
        for (int i = 0; i < 4; i++)
        begin
            power_up(i, 1'b1);
            power_down(i);
        end
        power_up(0, 1'b1);
        ch_fault[1] = 1'b1;
        step(20);
        ch_fault[1] = 1'b0;
        step(40);
        `CHK(ch_enable, 3'h7)
        ch_fault[1] = 1'b1;
        wait_for(0, 1'b0, 33);
        `CHK(ch_enable, 3'h0)
        ch_fault[1] = 1'b0;
        force_idle();
        power_up(0, 1'b1);
        force_shutdown_req = 1'b1;
        step(1);
        `CHK({ch_enable, system_reset_out_n}, 4'h0)
        force_idle();
        stuck = 1'b1;
        for (int a = 1; a < 4; a++)
        begin
            seq_abort_sel = 2'(a);
            power_up(0, 1'b0);
            wait_for(2, 1'b0, 1000 * (1 << (a - 1)) + 2);
            force_idle();
        end
        seq_abort_sel = 2'h0;
        power_up(0, 1'b0);
        step(4100);
        `CHK(ch_enable, 3'h7)
        stuck = 1'b0;
        wait_for(N, 1'b1, 504);
        power_down(0);
        battery_low = 1'b1;
        step(4);
        `CHK(battery_fault_out_n, 1'b0)
        battery_low = 1'b0;
        wait_for(N + 1, 1'b1, 62);
        supply_fail_cmp = 1'b1;
        step(4);
        supply_fail_cmp = 1'b0;
        step(3);
        supply_fail_clear = 1'b1;
        step(1);
        supply_fail_clear = 1'b0;
        `CHK(supply_fail_out, 1'b1)
        wait_for(N + 2, 1'b0, 60);
        scl_in = 1'b0;
        sda_in = 1'b0;
        step(1);
        scl_in = 1'b1;
        sda_in = 1'b1;
        repeat (6)
        begin
            step(1);
            `CHK({scl_filt, sda_filt}, 2'h3)
        end
        scl_in = 1'b0;
        sda_in = 1'b0;
        step(6);
        `CHK({scl_filt, sda_filt}, 2'h0)
        finish_test();
    end
endmodule : test_ssft_sequencer
`default_nettype wire
